// ---- dv/dagu_dec_model.sv ----
module dagu_dec_model (
  input  wire logic          core_clk,
  output dagu_pkg::dagu_req_s dec_req,
  output dagu_pkg::dagu_wr_s  ex_idx_wr,
  output dagu_pkg::dagu_wr_s  ex_nm_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  dagu_pkg::dagu_wr_s pend_i;
  dagu_pkg::dagu_wr_s pend_n;
  dagu_pkg::dagu_wr_s last_i;
  initial begin
    dec_req = '0;
    ex_idx_wr = '0;
    ex_nm_wr = '0;
    pend_i = '0;
    pend_n = '0;
    last_i = '0;
  end
  // one cycle per call; every signal is assigned once per falling edge
  task automatic step(input dagu_pkg::dagu_req_s r);
    dec_req = r;
    ex_idx_wr = pend_i;
    ex_nm_wr = pend_n;
    last_i = pend_i;
    pend_i = '0;
    pend_n = '0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // queue an execute-stage write for the next step
  task automatic exq(input logic nm, input dagu_pkg::dagu_sel_t s,
                     input dagu_pkg::dagu_word_t d);
    if (nm)
      pend_n = '{1'h1, s, d};
    else
      pend_i = '{1'h1, s, d};
  endtask
  task automatic exw(input logic nm, input dagu_pkg::dagu_sel_t s,
                     input dagu_pkg::dagu_word_t d);
    exq(nm, s, d);
    step('0);
  endtask
  // an index register just written in execute is not addressed next cycle
  task automatic issue(input dagu_pkg::dagu_req_s r);
    if (r.valid && last_i.we && (last_i.sel == r.idx ||
        last_i.sel == r.src || last_i.sel == r.y_idx))
      step('0);
    step(r);
  endtask
endmodule

// ---- dv/dsp_address_generation_unit_tb_top.sv ----
module dsp_address_generation_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 core_clk;
  logic                 reset;
  logic                 ce;
  dagu_pkg::dagu_sel_t  rd_sel;
  dagu_pkg::dagu_req_s  dec_req;
  dagu_pkg::dagu_wr_s   ex_idx_wr;
  dagu_pkg::dagu_wr_s   ex_nm_wr;
  dagu_pkg::dagu_word_t rd_idx;
  dagu_pkg::dagu_word_t rd_nm;
  dagu_pkg::dagu_addr_s addr_out;
  logic                 req_error;
  int                   miscompares;
  int                   cmp_count;
  always #50 core_clk = ~core_clk;
  dagu_core i_dagu_core (.core_clk(core_clk), .reset(reset), .ce(ce),
    .dec_req(dec_req), .ex_idx_wr(ex_idx_wr), .ex_nm_wr(ex_nm_wr),
    .rd_sel(rd_sel), .rd_idx(rd_idx), .rd_nm(rd_nm),
    .addr_out(addr_out), .req_error(req_error));
  dagu_dec_model i_dagu_dec_model (.core_clk(core_clk), .dec_req(dec_req),
    .ex_idx_wr(ex_idx_wr), .ex_nm_wr(ex_nm_wr));
  task automatic chk_w(input dagu_pkg::dagu_word_t g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_b(input logic g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask
  task automatic chk_reg(input dagu_pkg::dagu_sel_t s,
                         input dagu_pkg::dagu_word_t e);
    rd_sel = s;
    #1;
    chk_w(rd_idx, e, "index register");
  endtask
  function automatic dagu_pkg::dagu_req_s mk(input dagu_pkg::dagu_op_e o,
      input dagu_pkg::dagu_space_e sp, input dagu_pkg::dagu_sel_t i,
      input dagu_pkg::dagu_upd_e u, input dagu_pkg::dagu_sel_t s,
      input dagu_pkg::dagu_word_t imm);
    mk = '{1'h1, o, sp, i, u, s, 1'h0, imm, 4'h0, dagu_pkg::UP_NONE};
  endfunction
  // carry runs from msb toward lsb
  function automatic dagu_pkg::dagu_word_t revadd(
      input dagu_pkg::dagu_word_t a, b);
    dagu_pkg::dagu_word_t ra;
    dagu_pkg::dagu_word_t rb;
    dagu_pkg::dagu_word_t s;
    ra = {<<{a}};
    rb = {<<{b}};
    s = ra + rb;
    revadd = {<<{s}};
  endfunction
  task automatic t_reset();
    for (int s = 0; s < 13; s++)
      chk_reg(4'(s), 16'h0000);
    chk_b(req_error, 1'h0, "reset error flag");
    $display("test reset done");
  endtask
  task automatic t_load();
    dagu_pkg::dagu_req_s r;
    i_dagu_dec_model.exw(1'h0, 4'h3, 16'h1234);
    chk_reg(4'h3, 16'h1234);
    r = mk(dagu_pkg::OP_ADD_FULL, dagu_pkg::SP_X, 4'h0, dagu_pkg::UP_NONE,
           4'hc, 16'h0040);
    r.zero_base = 1'h1;
    // read port left on the add target while the add lands
    chk_reg(4'h0, 16'h0000);
    i_dagu_dec_model.issue(r);
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_INDEXED, dagu_pkg::SP_X, 4'h0,
                              dagu_pkg::UP_INC1, 4'h0, 16'h0000));
    chk_b(addr_out.x_valid, 1'h1, "x valid");
    chk_w(addr_out.x_addr, 16'h0040, "x address");
    chk_reg(4'h0, 16'h0041);
    $display("test load done");
  endtask
  task automatic t_upd();
    dagu_pkg::dagu_upd_e ul[6];
    int dl[6];
    dagu_pkg::dagu_word_t v;
    ul = '{dagu_pkg::UP_INC1, dagu_pkg::UP_DEC1, dagu_pkg::UP_INC2,
           dagu_pkg::UP_DEC2, dagu_pkg::UP_ADDN, dagu_pkg::UP_SUBN};
    dl = '{1, -1, 2, -2, 5, -5};
    v = 16'h0100;
    i_dagu_dec_model.exw(1'h1, 4'h2, 16'h0005);
    i_dagu_dec_model.exw(1'h0, 4'h2, v);
    for (int k = 0; k < 6; k++) begin
      i_dagu_dec_model.issue(mk(dagu_pkg::OP_INDEXED, dagu_pkg::SP_P, 4'h2,
                                ul[k], 4'h0, 16'h0000));
      chk_b(addr_out.p_valid, 1'h1, "p valid");
      chk_w(addr_out.p_addr, v, "p address");
      v = v + 16'(dl[k]);
    end
    chk_reg(4'h2, v);
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_UPDATE, dagu_pkg::SP_X, 4'h2,
                              dagu_pkg::UP_SUBN, 4'h0, 16'h0000));
    chk_b(addr_out.x_valid, 1'h0, "no move");
    chk_reg(4'h2, v - 16'h0005);
    $display("test updates done");
  endtask
  task automatic t_mod();
    i_dagu_dec_model.exw(1'h1, 4'h2, 16'h3000);
    i_dagu_dec_model.exw(1'h1, 4'h3, 16'hf000);
    i_dagu_dec_model.exw(1'h0, 4'h2, 16'h003f);
    rd_sel = 4'h2;
    #1;
    chk_w(rd_nm, 16'h3000, "modulo-offset readback");
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_ADD_FULL, dagu_pkg::SP_X, 4'h3,
                              dagu_pkg::UP_NONE, 4'h2, 16'h0001));
    chk_reg(4'h3, 16'h0030);
    // last word of the 16-word buffer steps back to its base
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_INDEXED, dagu_pkg::SP_X, 4'h2,
                              dagu_pkg::UP_INC1, 4'h0, 16'h0000));
    chk_w(addr_out.x_addr, 16'h003f, "wrap address");
    chk_reg(4'h2, 16'h0030);
    $display("test modulo add done");
  endtask
  task automatic t_rev();
    dagu_pkg::dagu_word_t v;
    v = 16'h0000;
    // block of 8 words, offset is half the block
    i_dagu_dec_model.exw(1'h1, 4'h5, 16'hf004);
    i_dagu_dec_model.exw(1'h0, 4'h5, v);
    for (int k = 0; k < 9; k++) begin
      i_dagu_dec_model.issue(mk(dagu_pkg::OP_INDEXED, dagu_pkg::SP_Y, 4'h5,
                                dagu_pkg::UP_ADDN, 4'h0, 16'h0000));
      chk_w(addr_out.y_addr, v, "reversed address");
      v = revadd(v, 16'h0004);
    end
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_INDEXED, dagu_pkg::SP_Y, 4'h5,
                              dagu_pkg::UP_INC1, 4'h0, 16'h0000));
    chk_reg(4'h5, v + 16'h0001);
    $display("test reverse done");
  endtask
  task automatic t_imm();
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_LONG_IMM, dagu_pkg::SP_Y, 4'h0,
                              dagu_pkg::UP_NONE, 4'h0, 16'hfedc));
    chk_b(addr_out.x_valid, 1'h0, "x quiet");
    chk_w(addr_out.y_addr, 16'hfedc, "long address");
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_LONG_IMM, dagu_pkg::SP_X, 4'h0,
                              dagu_pkg::UP_NONE, 4'h0, 16'h89ab));
    chk_b(addr_out.y_valid, 1'h0, "y quiet");
    chk_w(addr_out.x_addr, 16'h89ab, "long x address");
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_SHORT_IMM, dagu_pkg::SP_XY, 4'h0,
                              dagu_pkg::UP_NONE, 4'h0, 16'hffff));
    chk_b(addr_out.xy, 1'h1, "xy flag");
    chk_w(addr_out.x_addr, 16'h003f, "short x");
    chk_w(addr_out.y_addr, 16'h003f, "short y");
    $display("test immediate done");
  endtask
  task automatic t_par();
    dagu_pkg::dagu_req_s r;
    i_dagu_dec_model.exw(1'h0, 4'h0, 16'h0010);
    i_dagu_dec_model.exw(1'h1, 4'h0, 16'h0003);
    i_dagu_dec_model.exw(1'h0, 4'h4, 16'h0020);
    r = mk(dagu_pkg::OP_PAR, dagu_pkg::SP_X, 4'h0, dagu_pkg::UP_ADDN, 4'h0,
           16'h0000);
    r.y_idx = 4'h4;
    r.y_upd = dagu_pkg::UP_DEC1;
    i_dagu_dec_model.issue(r);
    chk_b(addr_out.y_valid, 1'h1, "y slot");
    chk_w(addr_out.x_addr, 16'h0010, "x slot");
    chk_w(addr_out.y_addr, 16'h0020, "y slot");
    chk_reg(4'h0, 16'h0013);
    chk_reg(4'h4, 16'h001f);
    i_dagu_dec_model.exw(1'h0, 4'h9, 16'h0100);
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_ADD_SHORT, dagu_pkg::SP_X, 4'ha,
                              dagu_pkg::UP_NONE, 4'h9, 16'hffff));
    chk_reg(4'ha, 16'h013f);
    $display("test parallel done");
  endtask
  task automatic t_refuse();
    dagu_pkg::dagu_req_s r[6];
    r[0] = mk(dagu_pkg::OP_LONG_IMM, dagu_pkg::SP_XY, 4'h0,
              dagu_pkg::UP_NONE, 4'h0, 16'h0000);
    r[1] = mk(dagu_pkg::OP_SHORT_IMM, dagu_pkg::SP_P, 4'h0,
              dagu_pkg::UP_NONE, 4'h0, 16'h0000);
    r[2] = mk(dagu_pkg::OP_INDEXED, dagu_pkg::SP_X, 4'hc,
              dagu_pkg::UP_INC1, 4'h0, 16'h0000);
    r[3] = mk(dagu_pkg::OP_PAR, dagu_pkg::SP_X, 4'h2,
              dagu_pkg::UP_INC1, 4'h0, 16'h0000);
    r[4] = mk(dagu_pkg::OP_PAR, dagu_pkg::SP_X, 4'h1,
              dagu_pkg::UP_INC2, 4'h0, 16'h0000);
    r[5] = mk(dagu_pkg::OP_ADD_SHORT, dagu_pkg::SP_X, 4'h2,
              dagu_pkg::UP_NONE, 4'h7, 16'h0001);
    r[3].y_idx = 4'h4;
    r[4].y_idx = 4'h5;
    for (int k = 0; k < 6; k++) begin
      i_dagu_dec_model.issue(r[k]);
      chk_b(req_error, 1'h1, "refused");
      chk_b(addr_out.x_valid, 1'h0, "refused address");
    end
    chk_reg(4'h2, 16'h0030);
    chk_reg(4'h1, 16'h0000);
    $display("test refusals done");
  endtask
  task automatic t_coll();
    dagu_pkg::dagu_req_s r;
    r = mk(dagu_pkg::OP_ADD_FULL, dagu_pkg::SP_X, 4'h0, dagu_pkg::UP_NONE,
           4'h0, 16'hdddd);
    r.zero_base = 1'h1;
    i_dagu_dec_model.exq(1'h0, 4'h0, 16'hbeef);
    i_dagu_dec_model.issue(r);
    chk_reg(4'h0, 16'hbeef);
    chk_reg(4'h1, 16'h0000);
    ce = 1'h0;
    i_dagu_dec_model.issue(mk(dagu_pkg::OP_UPDATE, dagu_pkg::SP_X, 4'h1,
                              dagu_pkg::UP_INC1, 4'h0, 16'h0000));
    ce = 1'h1;
    chk_reg(4'h1, 16'h0000);
    $display("test collision done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    core_clk = 1'h0;
    reset = 1'h1;
    ce = 1'h1;
    rd_sel = 4'h0;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'h0;
    t_reset();
    t_load();
    t_upd();
    t_mod();
    t_rev();
    t_imm();
    t_par();
    t_refuse();
    t_coll();
    tally_and_finish();
  end
endmodule

// ---- src/dagu_core.sv ----
`include "dagu_params.svh"
module dagu_core (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire dagu_pkg::dagu_req_s dec_req,
  input  wire dagu_pkg::dagu_wr_s  ex_idx_wr,
  input  wire dagu_pkg::dagu_wr_s  ex_nm_wr,
  input  wire dagu_pkg::dagu_sel_t rd_sel,
  output dagu_pkg::dagu_word_t     rd_idx,
  output dagu_pkg::dagu_word_t     rd_nm,
  output dagu_pkg::dagu_addr_s     addr_out,
  output logic                     req_error
);
  dagu_pkg::dagu_word_t idx_q [`DAGU_NREG];
  dagu_pkg::dagu_word_t nm_q  [`DAGU_NREG];
  logic                 wa_en;
  logic                 wb_en;
  dagu_pkg::dagu_sel_t  wa_sel;
  dagu_pkg::dagu_sel_t  wb_sel;
  dagu_pkg::dagu_word_t wa_val;
  dagu_pkg::dagu_word_t wb_val;
  dagu_pkg::dagu_addr_s next_addr;
  logic                 next_err;

  function automatic dagu_pkg::dagu_word_t rev16(
    input dagu_pkg::dagu_word_t a);
    dagu_pkg::dagu_word_t m;
    m = {<<{a}};
    return m;
  endfunction

  function automatic dagu_pkg::dagu_word_t offs(
    input dagu_pkg::dagu_word_t nm);
    return {{(`DAGU_MODE_MSB-`DAGU_OFF_MSB){nm[`DAGU_OFF_MSB]}},
            nm[`DAGU_OFF_MSB:0]};
  endfunction

  // core arithmetic shared by post-updates and index-add
  function automatic dagu_pkg::dagu_word_t agen(
    input dagu_pkg::dagu_word_t iv,
    input dagu_pkg::dagu_word_t nm,
    input dagu_pkg::dagu_word_t st,
    input logic                 rev_ok);
    logic [3:0]           mode;
    dagu_pkg::dagu_word_t mask;
    dagu_pkg::dagu_word_t mag;
    mode = nm[`DAGU_MODE_MSB:`DAGU_MODE_LSB];
    mask = `DAGU_ONES >> (`DAGU_MODE_TOP - mode);
    mag  = st[`DAGU_W-1] ? (~st + `DAGU_ONE) : st;
    if (mode == `DAGU_MODE_REV) begin
      // reversed carry chain: msb first, as rev-add-rev
      if (rev_ok)
        return rev16(rev16(iv) + rev16(st));
      return iv + st;
    end
    if (mode == `DAGU_MODE_LINEAR || mag > mask)
      return iv + st;
    // base stays, low bits wrap inside the power-of-two buffer
    return (iv & ~mask) | ((iv + st) & mask);
  endfunction

  function automatic dagu_pkg::dagu_word_t stepv(
    input dagu_pkg::dagu_upd_e  u,
    input dagu_pkg::dagu_word_t nm);
    case (u)
      dagu_pkg::UP_INC1: return `DAGU_ONE;
      dagu_pkg::UP_DEC1: return `DAGU_ONES;
      dagu_pkg::UP_INC2: return `DAGU_TWO;
      dagu_pkg::UP_DEC2: return ~`DAGU_TWO + `DAGU_ONE;
      dagu_pkg::UP_ADDN: return offs(nm);
      dagu_pkg::UP_SUBN: return ~offs(nm) + `DAGU_ONE;
      default:           return `DAGU_RST;
    endcase
  endfunction

  function automatic dagu_pkg::dagu_word_t upd_of(
    input dagu_pkg::dagu_sel_t s,
    input dagu_pkg::dagu_upd_e u,
    input dagu_pkg::dagu_word_t iv,
    input dagu_pkg::dagu_word_t nm);
    return agen(iv, nm, stepv(u, nm),
                u == dagu_pkg::UP_ADDN);
  endfunction

  // plain reads bypass the pipeline; last write is visible now
  assign rd_idx = (rd_sel < `DAGU_NREG) ? idx_q[rd_sel]
                                        : `DAGU_RST;
  assign rd_nm  = (rd_sel < `DAGU_NREG) ? nm_q[rd_sel] : `DAGU_RST;

  // decode-stage address and update formation
  always_comb begin
    logic                 bad;
    dagu_pkg::dagu_sel_t  s;
    dagu_pkg::dagu_word_t a;
    bad       = 1'b0;
    s         = dec_req.src;
    a         = `DAGU_RST;
    wa_en     = 1'b0;
    wb_en     = 1'b0;
    wa_sel    = dec_req.idx;
    wb_sel    = dec_req.y_idx;
    wa_val    = `DAGU_RST;
    wb_val    = `DAGU_RST;
    next_addr = '0;
    if (dec_req.idx >= `DAGU_NREG)
      bad = 1'b1;
    if (dec_req.valid && !bad) begin
      case (dec_req.op)
        dagu_pkg::OP_LONG_IMM: begin
          if (dec_req.space == dagu_pkg::SP_X ||
              dec_req.space == dagu_pkg::SP_Y)
            a = dec_req.imm;
          else
            bad = 1'b1;
        end
        dagu_pkg::OP_SHORT_IMM: begin
          if (dec_req.space == dagu_pkg::SP_P)
            bad = 1'b1;
          a = {{`DAGU_SHORT_PAD{1'b0}},
               dec_req.imm[`DAGU_SHORT_MSB:0]};
        end
        dagu_pkg::OP_INDEXED, dagu_pkg::OP_UPDATE: begin
          a      = idx_q[dec_req.idx];
          wa_en  = dec_req.upd != dagu_pkg::UP_NONE;
          wa_val = upd_of(dec_req.idx, dec_req.upd,
                          idx_q[dec_req.idx], nm_q[dec_req.idx]);
        end
        dagu_pkg::OP_PAR: begin
          // X slot from 0/1, Y slot from 4/5, short update menu
          if (!(dec_req.idx == `DAGU_PAR_X0 ||
                dec_req.idx == `DAGU_PAR_X1) ||
              !(dec_req.y_idx == `DAGU_PAR_Y0 ||
                dec_req.y_idx == `DAGU_PAR_Y1) ||
              dec_req.upd == dagu_pkg::UP_INC2 ||
              dec_req.upd == dagu_pkg::UP_DEC2 ||
              dec_req.upd == dagu_pkg::UP_SUBN ||
              dec_req.y_upd == dagu_pkg::UP_INC2 ||
              dec_req.y_upd == dagu_pkg::UP_DEC2 ||
              dec_req.y_upd == dagu_pkg::UP_SUBN)
            bad = 1'b1;
          else begin
            a      = idx_q[dec_req.idx];
            wa_en  = dec_req.upd != dagu_pkg::UP_NONE;
            wa_val = upd_of(dec_req.idx, dec_req.upd,
                            idx_q[dec_req.idx], nm_q[dec_req.idx]);
            wb_en  = dec_req.y_upd != dagu_pkg::UP_NONE;
            wb_val = upd_of(dec_req.y_idx, dec_req.y_upd,
                            idx_q[dec_req.y_idx],
                            nm_q[dec_req.y_idx]);
          end
        end
        dagu_pkg::OP_ADD_FULL: begin
          if (!dec_req.zero_base && s >= `DAGU_NREG)
            bad = 1'b1;
          else begin
            wa_en  = 1'b1;
            // zero base loads the immediate as is
            wa_val = dec_req.zero_base ? dec_req.imm
                   : agen(idx_q[s], nm_q[s], dec_req.imm,
                          1'b1);
          end
        end
        dagu_pkg::OP_ADD_SHORT: begin
          if (s < `DAGU_SADD_LO || s > `DAGU_SADD_HI)
            bad = 1'b1;
          else begin
            wa_en  = 1'b1;
            wa_val = agen(idx_q[s], nm_q[s],
                          {{`DAGU_SHORT_PAD{1'b0}},
                           dec_req.imm[`DAGU_SHORT_MSB:0]},
                          1'b1);
          end
        end
        default: ;
      endcase
    end
    if (bad) begin
      wa_en = 1'b0;
      wb_en = 1'b0;
    end else if (dec_req.valid) begin
      case (dec_req.op)
        dagu_pkg::OP_LONG_IMM, dagu_pkg::OP_SHORT_IMM,
        dagu_pkg::OP_INDEXED: begin
          next_addr.xy      = dec_req.space == dagu_pkg::SP_XY;
          next_addr.x_valid = dec_req.space == dagu_pkg::SP_X ||
                              next_addr.xy;
          next_addr.y_valid = dec_req.space == dagu_pkg::SP_Y ||
                              next_addr.xy;
          next_addr.p_valid = dec_req.space == dagu_pkg::SP_P;
          next_addr.x_addr  = a;
          next_addr.y_addr  = a;
          next_addr.p_addr  = a;
        end
        dagu_pkg::OP_PAR: begin
          next_addr.x_valid = 1'b1;
          next_addr.x_addr  = a;
          next_addr.y_valid = 1'b1;
          next_addr.y_addr  = idx_q[dec_req.y_idx];
        end
        default: ;
      endcase
    end
    next_err = dec_req.valid && bad;
  end

  for (genvar g = 0; g < `DAGU_NREG; g++) begin : g_reg
    always_ff @(posedge core_clk) begin
      if (reset)
        idx_q[g] <= `DAGU_RST;
      else if (ce) begin
        // execute write wins; the decode value is simply dropped
        if (ex_idx_wr.we && ex_idx_wr.sel == 4'(g))
          idx_q[g] <= ex_idx_wr.data;
        else if (wa_en && wa_sel == 4'(g))
          idx_q[g] <= wa_val;
        else if (wb_en && wb_sel == 4'(g))
          idx_q[g] <= wb_val;
      end
    end
    always_ff @(posedge core_clk) begin
      if (reset)
        nm_q[g] <= `DAGU_RST;
      else if (ce && ex_nm_wr.we && ex_nm_wr.sel == 4'(g))
        nm_q[g] <= ex_nm_wr.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_out  <= '0;
      req_error <= 1'b0;
    end else if (ce) begin
      addr_out  <= next_addr;
      req_error <= next_err;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // mode and buffer mask of the add source, for the add checks
  logic [3:0]           src_mode;
  dagu_pkg::dagu_word_t src_mask;
  assign src_mode = (dec_req.src < `DAGU_NREG) ?
                    nm_q[dec_req.src][`DAGU_MODE_MSB:`DAGU_MODE_LSB] : 4'h0;
  assign src_mask = `DAGU_ONES >> (`DAGU_MODE_TOP - src_mode);

  sequence dec_upd_s;
    ce && wa_en && !(ex_idx_wr.we && ex_idx_wr.sel == wa_sel);
  endsequence

  long_imm_addr_a: assert property (
    ce && dec_req.valid && dec_req.op == dagu_pkg::OP_LONG_IMM &&
    dec_req.space == dagu_pkg::SP_X && dec_req.idx < `DAGU_NREG
    |=> addr_out.x_valid && addr_out.x_addr == $past(dec_req.imm))
    else $error("long immediate address wrong");
  short_imm_low_a: assert property (
    ce && dec_req.valid && dec_req.op == dagu_pkg::OP_SHORT_IMM
    |=> addr_out.x_addr[`DAGU_W-1:`DAGU_SHORT_MSB+1] == '0)
    else $error("short immediate reaches past 64 words");
  xy_same_addr_a: assert property (
    addr_out.xy |-> addr_out.x_valid && addr_out.y_valid &&
    addr_out.x_addr == addr_out.y_addr)
    else $error("xy access addresses differ");
  ex_beats_dec_a: assert property (
    ce && wa_en && ex_idx_wr.we && ex_idx_wr.sel == wa_sel &&
    wa_sel < `DAGU_NREG
    |=> idx_q[$past(wa_sel)] == $past(ex_idx_wr.data))
    else $error("decode write beat execute write");
  add_ready_next_a: assert property (
    dec_upd_s ##0 (dec_req.op == dagu_pkg::OP_ADD_FULL &&
                   dec_req.zero_base)
    |=> rd_sel != $past(wa_sel) || rd_idx == $past(dec_req.imm))
    else $error("zero-base add not visible next cycle");
  lin_inc_a: assert property (
    dec_upd_s ##0 ((dec_req.op == dagu_pkg::OP_UPDATE ||
                    dec_req.op == dagu_pkg::OP_INDEXED) &&
    dec_req.upd == dagu_pkg::UP_INC1 &&
    nm_q[dec_req.idx][`DAGU_MODE_MSB:`DAGU_MODE_LSB] == 4'h0)
    |=> idx_q[$past(wa_sel)] == $past(idx_q[dec_req.idx]) + 16'h0001)
    else $error("linear increment wrong");
  rev_step_a: assert property (
    dec_upd_s ##0 ((dec_req.op == dagu_pkg::OP_UPDATE ||
                    dec_req.op == dagu_pkg::OP_INDEXED) &&
    dec_req.upd == dagu_pkg::UP_ADDN &&
    nm_q[dec_req.idx][`DAGU_MODE_MSB:`DAGU_MODE_LSB] == 4'hf)
    |=> rev16(idx_q[$past(wa_sel)]) - rev16($past(idx_q[dec_req.idx]))
        == rev16(offs($past(nm_q[dec_req.idx]))))
    else $error("bit-reversed step wrong");
  par_x_legal_a: assert property (
    ce && dec_req.valid && dec_req.op == dagu_pkg::OP_PAR &&
    dec_req.idx > 4'h1 |=> req_error ##1 1'b1)
    else $error("illegal parallel index accepted");
  sadd_src_a: assert property (
    ce && dec_req.valid && dec_req.op == dagu_pkg::OP_ADD_SHORT &&
    dec_req.src < 4'h8 |-> !wa_en ##1 req_error)
    else $error("short add from illegal source");
  par_y_slot_a: assert property (
    ce && dec_req.valid && dec_req.op == dagu_pkg::OP_PAR && !next_err
    |=> addr_out.y_valid && addr_out.y_addr == $past(idx_q[dec_req.y_idx]))
    else $error("parallel y slot address wrong");
  refused_quiet_a: assert property (
    ce && next_err |=> req_error && !addr_out.x_valid &&
    !addr_out.y_valid && !addr_out.p_valid)
    else $error("refused request left an address");
  ce_freeze_a: assert property (
    !ce |=> $stable(addr_out) && $stable(req_error))
    else $error("outputs moved while clock enable low");
  sadd_sum_a: assert property (
    dec_upd_s ##0 (dec_req.op == dagu_pkg::OP_ADD_SHORT && src_mode == 4'h0)
    |=> idx_q[$past(wa_sel)] == $past(idx_q[dec_req.src]) +
        {10'h000, $past(dec_req.imm[5:0])})
    else $error("short index add sum wrong");
  // small steps under a circular source mode stay in the source buffer
  add_in_buf_a: assert property (
    dec_upd_s ##0 (dec_req.op == dagu_pkg::OP_ADD_FULL &&
    !dec_req.zero_base && src_mode != 4'h0 && src_mode != 4'hf &&
    dec_req.imm <= src_mask)
    |=> ((idx_q[$past(wa_sel)] ^ $past(idx_q[dec_req.src])) &
         ~$past(src_mask)) == 16'h0000)
    else $error("index add left the source buffer");
endmodule

// ---- src/dagu_params.svh ----
`ifndef DAGU_PARAMS_SVH
`define DAGU_PARAMS_SVH
// Contract
// - mode nibble 0xf selects bit-reversed index arithmetic
// - bit-reversed stepping applies to the plus-offset update only; index-add under mode 0xf is bit-reversed too
// - long immediate gives a 16-bit absolute X or Y address
// - short immediate gives a 6-bit address in X, Y or XY
// - XY access drives the same address to X and Y together
// - two 8-bit moves pair only as one X and one Y move
// - long indexed uses any of twelve registers, post-modified
// - offset amount comes from the paired modulo-offset register
// - parallel moves use index 0/1 for X, 4/5 for Y, +-1, +n
// - every standard update may run without a memory move
// - full index-add writes source plus 16-bit immediate to target
// - short index-add takes 6-bit immediate, source index 8 to 11
// - index-add wraps under the source register's mode
// - index loads by move, immediate, or zero base plus immediate
// - address-unit index updates happen in the decode stage
// - non-address reads see the previous write immediately
// - index-add result is usable by the very next instruction
// - execute-stage write beats a same-cycle decode-stage write
// - modulo-offset holds mode in [15:12], signed offset [11:0]
// - mode 0 linear, 1 to 14 circular with size 2^(m+1)
// - twelve 16-bit index registers paired with modulo-offsets
`define DAGU_NREG        12
`define DAGU_W           16
`define DAGU_SEL_W       4
`define DAGU_MODE_MSB    15
`define DAGU_MODE_LSB    12
`define DAGU_OFF_MSB     11
`define DAGU_MODE_LINEAR 4'h0
`define DAGU_MODE_REV    4'hf
`define DAGU_MODE_TOP    4'hf
`define DAGU_SHORT_MSB   5
`define DAGU_SHORT_PAD   10
`define DAGU_SADD_LO     4'h8
`define DAGU_SADD_HI     4'hb
`define DAGU_PAR_X0      4'h0
`define DAGU_PAR_X1      4'h1
`define DAGU_PAR_Y0      4'h4
`define DAGU_PAR_Y1      4'h5
`define DAGU_RST         16'h0000
`define DAGU_ONE         16'h0001
`define DAGU_TWO         16'h0002
`define DAGU_ONES        16'hffff
`endif

// ---- src/dagu_pkg.sv ----
`include "dagu_params.svh"
package dagu_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_LONG_IMM, OP_SHORT_IMM, OP_INDEXED,
    OP_PAR, OP_UPDATE, OP_ADD_FULL, OP_ADD_SHORT
  } dagu_op_e;
  typedef enum logic [1:0] {SP_X, SP_Y, SP_XY, SP_P} dagu_space_e;
  typedef enum logic [2:0] {
    UP_NONE, UP_INC1, UP_DEC1, UP_INC2, UP_DEC2, UP_ADDN, UP_SUBN
  } dagu_upd_e;
  typedef logic [`DAGU_W-1:0]     dagu_word_t;
  typedef logic [`DAGU_SEL_W-1:0] dagu_sel_t;
  typedef struct packed {
    logic        valid;
    dagu_op_e    op;
    dagu_space_e space;
    dagu_sel_t   idx;
    dagu_upd_e   upd;
    dagu_sel_t   src;
    logic        zero_base;
    dagu_word_t  imm;
    dagu_sel_t   y_idx;
    dagu_upd_e   y_upd;
  } dagu_req_s;
  typedef struct packed {
    logic       we;
    dagu_sel_t  sel;
    dagu_word_t data;
  } dagu_wr_s;
  typedef struct packed {
    logic       x_valid;
    dagu_word_t x_addr;
    logic       y_valid;
    dagu_word_t y_addr;
    logic       p_valid;
    dagu_word_t p_addr;
    logic       xy;
  } dagu_addr_s;
endpackage
